// *** include/fault_pkg.sv ***
// Shared constants and carrier types for the motor protection supervisor
package fault_pkg;

  localparam int HIST_DEPTH = 10;
  localparam int HIST_PTR_W = 4;
  localparam int LINK_MAX = 4;
  localparam int TRQ_LIMIT_MIN_PCT = 250;
  localparam int COMPAT_SPEED_ENTRY = 7;
  localparam int PCT_W = 10;
  localparam int POS_W = 32;
  localparam int VAL_W = 16;
  localparam int SPD_W = 16;
  localparam int SYNC_STAGES = 3;

  // Warning codes kept in the history
  localparam logic [3:0] WCODE_NONE = 4'h0;
  localparam logic [3:0] WCODE_DEV = 4'h1;
  localparam logic [3:0] WCODE_OVOLT = 4'h2;
  localparam logic [3:0] WCODE_OVLD = 4'h3;
  localparam logic [3:0] WCODE_PROHIB = 4'h4;

  // Alarm latch bit positions
  localparam int AB_INIT = 0;
  localparam int AB_REGEN = 1;
  localparam int AB_OVTR = 2;
  localparam int AB_DATA = 3;
  localparam int AB_MAINOUT = 4;
  localparam int ALARM_N = 5;

  localparam logic [ALARM_N-1:0] ALARM_RESET = 5'h00;
  localparam logic [ALARM_N-1:0] ALARM_CLEARABLE = 5'h1D;
  localparam logic [ALARM_N-1:0] ALARM_EXC_OFF = 5'h17;

  typedef enum logic [1:0] {
    PWR_WAIT = 2'b00,
    PWR_CHECK = 2'b01,
    PWR_RUN = 2'b10
  } pwr_state_e;

  typedef struct packed {
    logic [POS_W-1:0] cmd_pos;
    logic [POS_W-1:0] act_pos;
    logic [POS_W-1:0] dev_limit;
    logic [VAL_W-1:0] volt;
    logic [VAL_W-1:0] volt_limit;
    logic [VAL_W-1:0] load;
    logic [VAL_W-1:0] load_limit;
  } measure_s;

  typedef struct packed {
    logic start;
    logic positioning;
    logic compat_mode;
    logic [2:0] entry;
    logic [SPD_W-1:0] speed;
    logic [2:0] link_count;
    logic dir_mismatch;
  } op_req_s;

endpackage

// *** design/warn_history.sv ***
// Ten-entry warning history, newest at index 0
`timescale 1ns/100ps
module warn_history
  import fault_pkg::*;
#(
  parameter int DEPTH = HIST_DEPTH
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Write and clear
  input wire logic push_in,
  input wire logic [3:0] code_in,
  input wire logic clear_in,
  // Read
  input wire logic [HIST_PTR_W-1:0] rd_idx_in,
  output logic [3:0] rd_code_out,
  output logic [HIST_PTR_W-1:0] count_out
);

  logic [3:0] mem_reg [DEPTH];
  logic [3:0] mem_next [DEPTH];
  logic [HIST_PTR_W-1:0] count_reg, count_next;
  logic [3:0] rd_reg, rd_next;

  // Shift register: oldest falls off the end when full
  always_comb begin
    count_next = count_reg;
    for (int i = 0; i < DEPTH; i++) begin
      mem_next[i] = mem_reg[i];
    end
    if (clear_in) begin
      count_next = '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_next[i] = WCODE_NONE;
      end
    end else if (push_in) begin
      mem_next[0] = code_in;
      for (int i = 1; i < DEPTH; i++) begin
        mem_next[i] = mem_reg[i-1];
      end
      if (count_reg != HIST_PTR_W'(DEPTH)) begin
        count_next = count_reg + 1'b1;
      end
    end
    rd_next = (rd_idx_in < count_reg) ? mem_reg[rd_idx_in] : WCODE_NONE;
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      count_reg <= '0;
      rd_reg <= WCODE_NONE;
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= WCODE_NONE;
      end
    end else begin
      count_reg <= count_next;
      rd_reg <= rd_next;
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= mem_next[i];
      end
    end
  end

  assign rd_code_out = rd_reg;
  assign count_out = count_reg;

endmodule // warn_history

// *** design/motor_fault_warning_manager.sv ***
// Alarm and warning supervisor for a brushless motor driver
`timescale 1ns/100ps
// Overview of operation
// - Excitation-off alarms cut motor current and engage the brake.
// - Excitation-on alarms keep motor current and excitation.
// - Main-circuit-output alarm suppressed when torque limit is below 250 percent.
// - Power-up with an operation input on raises initial-drive alarm; fault clear clears it once the run input drops.
// - Initial-drive alarm only when its check setting is enabled.
// - Thermostat fault or main power before signal power: uncleared, excitation-off alarm.
// - Enabled software overtravel alarms when position reaches the limit.
// - Linked operation mixing rotation directions raises abnormal-data alarm.
// - Linking five or more entries raises abnormal-data alarm.
// - Positioning start at zero speed raises abnormal-data alarm, entry 7 compat too.
// - Abnormal-data alarm keeps excitation and is cleared by fault clear.
// - Any warning drives the caution output; operation continues.
// - Caution output drops by itself when the cause is gone.
// - While excited, deviation beyond threshold raises a warning.
// - Supply voltage above threshold raises a warning.
// - Load above the overload level raises a warning.
// - Leaving test mode with an operation input on raises a warning.
// - Keep up to ten warnings, newest first.
// - History can be read and cleared from panel or external tool.
// - History empty after power-up.
module motor_fault_warning_manager
  import fault_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Host pins (asynchronous)
  input wire logic fault_clear_input,
  input wire logic run_fwd_in,
  input wire logic run_rvs_in,
  input wire logic resistor_thermostat_input,
  // Power status (asynchronous)
  input wire logic main_power_in,
  input wire logic signal_power_in,
  input wire logic main_circuit_open_in,
  // Settings
  input wire logic init_drive_check_en_in,
  input wire logic soft_ovtr_en_in,
  input wire logic [POS_W-1:0] soft_limit_in,
  input wire logic [PCT_W-1:0] torque_limit_pct_in,
  input wire logic test_mode_in,
  // Measurements and operation requests
  input wire measure_s meas_in,
  input wire op_req_s op_in,
  // History access
  input wire logic hist_clear_panel_in,
  input wire logic hist_clear_tool_in,
  input wire logic [HIST_PTR_W-1:0] hist_idx_in,
  output logic [3:0] hist_code_out,
  output logic [HIST_PTR_W-1:0] hist_count_out,
  // Status
  output logic [ALARM_N-1:0] alarm_out,
  output logic excite_out,
  output logic brake_out,
  output logic caution_output,
  output logic [3:0] warn_active_out
);

  // Asynchronous pins pass three flops; change accepted when stages 2 and 3 agree
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] s1_reg, s2_reg, s3_reg, pin_reg;
  logic [NSYNC-1:0] pin_next;

  assign pin_raw = {main_circuit_open_in, signal_power_in, main_power_in,
                    resistor_thermostat_input, run_rvs_in, run_fwd_in, fault_clear_input};

  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      always_comb begin
        pin_next[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : pin_reg[g];
      end
    end
  endgenerate

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      pin_reg <= '0;
    end else begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      pin_reg <= pin_next;
    end
  end

  logic clr_s, fwd_s, rvs_s, th_bad_s, main_s, sig_s, open_s;
  assign clr_s = pin_reg[0];
  assign fwd_s = pin_reg[1];
  assign rvs_s = pin_reg[2];
  assign th_bad_s = pin_reg[3];
  assign main_s = pin_reg[4];
  assign sig_s = pin_reg[5];
  assign open_s = pin_reg[6];

  logic run_s;
  assign run_s = fwd_s | rvs_s;

  // Power-up sequencing
  pwr_state_e pwr_reg, pwr_next;
  logic main_prev_reg, main_prev_next;
  logic clr_prev_reg, clr_prev_next;
  logic test_prev_reg, test_prev_next;
  logic order_bad_reg, order_bad_next;
  // Initial-drive cause stays while the run input is still held
  logic init_pend_reg, init_pend_next;
  logic init_hit, main_rise;

  assign main_rise = main_s & ~main_prev_reg;

  always_comb begin
    pwr_next = pwr_reg;
    order_bad_next = order_bad_reg;
    init_hit = 1'b0;
    case (pwr_reg)
      PWR_WAIT: begin
        if (main_rise) begin
          pwr_next = PWR_CHECK;
          // Main supply ahead of signal supply
          order_bad_next = ~sig_s;
        end
      end
      PWR_CHECK: begin
        init_hit = run_s & init_drive_check_en_in;
        pwr_next = PWR_RUN;
      end
      PWR_RUN: begin
        if (!main_s) begin
          pwr_next = PWR_WAIT;
        end
      end
      default: pwr_next = PWR_WAIT;
    endcase
    main_prev_next = main_s;
    clr_prev_next = clr_s;
    test_prev_next = test_mode_in;
    init_pend_next = init_hit | (init_pend_reg & run_s);
  end

  // Alarm detection
  logic [ALARM_N-1:0] alarm_reg, alarm_next, alarm_set;
  logic clr_pulse, data_bad, ovtr_hit, zero_spd;

  assign clr_pulse = clr_s & ~clr_prev_reg;
  assign zero_spd = op_in.start & op_in.positioning & (op_in.speed == '0) &
                    (!op_in.compat_mode || op_in.entry == 3'(COMPAT_SPEED_ENTRY));
  assign data_bad = op_in.start & ((op_in.link_count > 3'(LINK_MAX))
                    | op_in.dir_mismatch
                    | zero_spd);
  assign ovtr_hit = soft_ovtr_en_in &
                    ($signed(meas_in.act_pos) >= $signed(soft_limit_in));

  always_comb begin
    alarm_set = ALARM_RESET;
    // Clear refused until the host drops the run input
    alarm_set[AB_INIT] = init_hit | (init_pend_reg & run_s);
    alarm_set[AB_REGEN] = th_bad_s | order_bad_reg;
    alarm_set[AB_OVTR] = ovtr_hit;
    alarm_set[AB_DATA] = data_bad;
    // Output-open check meaningless at low torque limits
    alarm_set[AB_MAINOUT] = open_s &
                            (torque_limit_pct_in >= PCT_W'(TRQ_LIMIT_MIN_PCT));
    alarm_next = alarm_reg;
    if (clr_pulse) begin
      alarm_next = alarm_reg & ~ALARM_CLEARABLE;
    end
    // New event wins over a simultaneous clear
    alarm_next = alarm_next | alarm_set;
  end

  // Excitation: only off-class alarms drop current
  logic excite_next, brake_next;
  always_comb begin
    excite_next = ~|(alarm_next & ALARM_EXC_OFF);
    brake_next = ~excite_next;
  end

  // Warnings are live levels; only the test-mode exit warning is latched, until run drops
  logic [3:0] warn_reg, warn_next, warn_new;
  logic [POS_W-1:0] dev_abs;
  logic prohib_reg, prohib_next;

  always_comb begin
    dev_abs = ($signed(meas_in.cmd_pos) >= $signed(meas_in.act_pos)) ?
              meas_in.cmd_pos - meas_in.act_pos : meas_in.act_pos - meas_in.cmd_pos;
    prohib_next = prohib_reg;
    if (test_prev_reg && !test_mode_in && run_s) begin
      prohib_next = 1'b1;
    end else if (!run_s) begin
      prohib_next = 1'b0;
    end
    warn_next[0] = excite_out & (dev_abs > meas_in.dev_limit);
    warn_next[1] = meas_in.volt > meas_in.volt_limit;
    warn_next[2] = meas_in.load > meas_in.load_limit;
    warn_next[3] = prohib_next;
    warn_new = warn_next & ~warn_reg;
  end

  // One push per cycle; lowest code wins if several rise together
  logic push;
  logic [3:0] push_code;
  always_comb begin
    push = |warn_new;
    push_code = WCODE_NONE;
    if (warn_new[3]) push_code = WCODE_PROHIB;
    if (warn_new[2]) push_code = WCODE_OVLD;
    if (warn_new[1]) push_code = WCODE_OVOLT;
    if (warn_new[0]) push_code = WCODE_DEV;
  end

  logic caution_next;
  assign caution_next = |warn_next;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      pwr_reg <= PWR_WAIT;
      main_prev_reg <= 1'b0;
      clr_prev_reg <= 1'b0;
      test_prev_reg <= 1'b0;
      order_bad_reg <= 1'b0;
      init_pend_reg <= 1'b0;
      alarm_reg <= ALARM_RESET;
      excite_out <= 1'b1;
      brake_out <= 1'b0;
      warn_reg <= 4'h0;
      prohib_reg <= 1'b0;
      caution_output <= 1'b0;
    end else begin
      pwr_reg <= pwr_next;
      main_prev_reg <= main_prev_next;
      clr_prev_reg <= clr_prev_next;
      test_prev_reg <= test_prev_next;
      order_bad_reg <= order_bad_next;
      init_pend_reg <= init_pend_next;
      alarm_reg <= alarm_next;
      excite_out <= excite_next;
      brake_out <= brake_next;
      warn_reg <= warn_next;
      prohib_reg <= prohib_next;
      caution_output <= caution_next;
    end
  end

  assign alarm_out = alarm_reg;
  assign warn_active_out = warn_reg;

  warn_history #(
    .DEPTH(HIST_DEPTH)
  ) u_hist (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .push_in(push),
    .code_in(push_code),
    .clear_in(hist_clear_panel_in | hist_clear_tool_in),
    .rd_idx_in(hist_idx_in),
    .rd_code_out(hist_code_out),
    .count_out(hist_count_out)
  );

endmodule // motor_fault_warning_manager

// *** verification/host_ctrl.sv ***
// Host controller model driving the run and fault-clear pins
`timescale 1ns/100ps
module host_ctrl (
  // Clock
  input wire logic mclk_in,
  // Requests from the bench: clear, reverse, forward
  input wire logic [2:0] req_in,
  input wire logic [1:0] lag_in,
  // Pins toward the supervisor
  output logic run_fwd_out,
  output logic run_rvs_out,
  output logic clear_out
);
  logic [11:0] pipe_reg = 12'h000;
  // Slow hosts act up to four cycles after being asked
  always_ff @(posedge mclk_in) begin
    pipe_reg <= {pipe_reg[8:0], req_in};
  end
  // Run pins are dropped on request to remove the cause
  assign {clear_out, run_rvs_out, run_fwd_out} = pipe_reg[3*lag_in +: 3];
endmodule // host_ctrl

// *** verification/motor_fault_warning_manager_assertions.sv ***
// Port checks for the motor protection supervisor
`timescale 1ns/100ps
module fault_checks
  import fault_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [PCT_W-1:0] torque_limit_pct_in,
  input wire measure_s meas_in,
  input wire op_req_s op_in,
  input wire logic hist_clear_panel_in,
  input wire logic hist_clear_tool_in,
  input wire logic [HIST_PTR_W-1:0] hist_count_out,
  input wire logic [ALARM_N-1:0] alarm_out,
  input wire logic excite_out,
  input wire logic brake_out,
  input wire logic caution_output,
  input wire logic [3:0] warn_active_out
);
  logic ovld;
  assign ovld = meas_in.load > meas_in.load_limit;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  sequence s_cut;
    (alarm_out & ALARM_EXC_OFF) != '0;
  endsequence
  sequence s_bad_op;
    op_in.start && ((op_in.positioning && op_in.speed == '0 && (!op_in.compat_mode
      || op_in.entry == 3'(COMPAT_SPEED_ENTRY))) || op_in.link_count > 3'h4 || op_in.dir_mismatch);
  endsequence
  a_exc_off_cut: assert property (s_cut |-> !excite_out && brake_out)
    else $error("current kept under cutting alarm");
  a_exc_on_keep: assert property (!(alarm_out & ALARM_EXC_OFF) |-> excite_out && !brake_out)
    else $error("excitation lost without cutting alarm");
  a_mainout_mask: assert property ($rose(alarm_out[AB_MAINOUT]) |-> $past(torque_limit_pct_in) >= TRQ_LIMIT_MIN_PCT)
    else $error("main output alarm below torque floor");
  a_data_alarm: assert property (s_bad_op |=> alarm_out[AB_DATA])
    else $error("bad operation data not flagged");
  a_regen_hold: assert property (alarm_out[AB_REGEN] |=> alarm_out[AB_REGEN])
    else $error("resistor alarm dropped");
  a_caution_any: assert property (caution_output == (warn_active_out != 4'h0))
    else $error("caution output disagrees with warnings");
  a_ovld_track: assert property (1'b1 |=> warn_active_out[2] == $past(ovld))
    else $error("overload warning wrong");
  a_ovolt_rise: assert property (meas_in.volt > meas_in.volt_limit |=> warn_active_out[1])
    else $error("overvoltage warning missing");
  a_hist_clear: assert property (hist_clear_panel_in || hist_clear_tool_in |=> hist_count_out == '0)
    else $error("history not cleared");
  a_hist_cap: assert property (hist_count_out <= 4'(HIST_DEPTH))
    else $error("history over capacity");
endmodule // fault_checks

// *** verification/tb.sv ***
// Self-checking bench for the motor protection supervisor
`timescale 1ns/100ps
module tb import fault_pkg::*;;
  logic mclk_in, rst_in, therm, main_pwr, sig_pwr, open_line, idc_en, ovtr_en, test_mode;
  logic clr_p, clr_t, exc, brk, caut, fwd, rvs, fclr, smp;
  logic [POS_W-1:0] soft_lim;
  logic [PCT_W-1:0] trq;
  measure_s meas;
  op_req_s op;
  logic [HIST_PTR_W-1:0] idx, cnt;
  logic [3:0] code, warn;
  logic [ALARM_N-1:0] alarm;
  logic [2:0] req;
  logic [1:0] lag;
  logic [19:0] q[$];
  int n_mismatch, checked;
  wire [19:0] obs = {alarm, exc, brk, caut, warn, cnt, code};
  motor_fault_warning_manager u_motor_fault_warning_manager (
    .mclk_in(mclk_in), .rst_in(rst_in), .fault_clear_input(fclr), .run_fwd_in(fwd),
    .run_rvs_in(rvs), .resistor_thermostat_input(therm), .main_power_in(main_pwr),
    .signal_power_in(sig_pwr), .main_circuit_open_in(open_line),
    .init_drive_check_en_in(idc_en), .soft_ovtr_en_in(ovtr_en), .soft_limit_in(soft_lim),
    .torque_limit_pct_in(trq), .test_mode_in(test_mode), .meas_in(meas), .op_in(op),
    .hist_clear_panel_in(clr_p), .hist_clear_tool_in(clr_t), .hist_idx_in(idx),
    .hist_code_out(code), .hist_count_out(cnt), .alarm_out(alarm), .excite_out(exc),
    .brake_out(brk), .caution_output(caut), .warn_active_out(warn));
  host_ctrl u_host_ctrl (.mclk_in(mclk_in), .req_in(req), .lag_in(lag), .run_fwd_out(fwd),
    .run_rvs_out(rvs), .clear_out(fclr));
  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  // Motor state follows alarm class, caution follows any warning
  function automatic logic [19:0] mk(input logic [4:0] a, input logic [3:0] w, c, h);
    mk = {a, (a & ALARM_EXC_OFF) == '0, (a & ALARM_EXC_OFF) != '0, |w, w, c, h};
  endfunction
  task automatic expect_obs(input int n, input logic [19:0] e);
    cyc(n);
    q.push_back(e);
    smp <= 1'b1;
    cyc(1);
    smp <= 1'b0;
  endtask
  // Held long enough to pass the input synchroniser
  task automatic pulse_clear;
    lag <= 2'($urandom_range(0, 3));
    req[2] <= 1'b1;
    cyc(6);
    req[2] <= 1'b0;
  endtask
  always @(posedge mclk_in) begin
    if (smp) begin
      checked++;
      if (obs !== q[0]) begin
        n_mismatch++;
        $display("mismatch status expected %h seen %h", q[0], obs);
      end
      void'(q.pop_front());
    end
  end
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    cyc(20000);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'h781B1C1F));
    {rst_in, sig_pwr, trq} = {2'b11, 10'h12C};
    {therm, main_pwr, open_line, idc_en, ovtr_en, test_mode, clr_p, clr_t, smp} = '0;
    {meas, op, idx, req, lag, n_mismatch, checked} = '0;
    soft_lim = 32'h7FFFFFFF;
    cyc(5);
    rst_in <= 1'b0;
    expect_obs(2, mk(5'h00, 4'h0, 4'h0, 4'h0));
    req <= 3'h1;
    main_pwr <= 1'b1;
    expect_obs(12, mk(5'h00, 4'h0, 4'h0, 4'h0));
    main_pwr <= 1'b0;
    idc_en <= 1'b1;
    cyc(8);
    main_pwr <= 1'b1;
    expect_obs(12, mk(5'h01, 4'h0, 4'h0, 4'h0));
    pulse_clear();
    expect_obs(12, mk(5'h01, 4'h0, 4'h0, 4'h0));
    req[1:0] <= 2'h0;
    cyc(8);
    pulse_clear();
    expect_obs(12, mk(5'h00, 4'h0, 4'h0, 4'h0));
    for (int i = 0; i < 5; i++) begin
      op.start <= 1'b1;
      op.positioning <= 1'b1;
      op.compat_mode <= (i == 1);
      op.entry <= (i == 1) ? 3'(COMPAT_SPEED_ENTRY) : 3'h2;
      op.speed <= (i < 2) ? 16'h0000 : 16'($urandom_range(1, 65535));
      op.link_count <= (i == 2) ? 3'($urandom_range(5, 7)) : 3'h4;
      op.dir_mismatch <= (i == 3);
      cyc(1);
      op.start <= 1'b0;
      expect_obs(2, mk((i == 4) ? 5'h00 : 5'h08, 4'h0, 4'h0, 4'h0));
      pulse_clear();
      expect_obs(12, mk(5'h00, 4'h0, 4'h0, 4'h0));
    end
    soft_lim <= 32'h00000200;
    meas.act_pos <= 32'h00000200;
    meas.cmd_pos <= 32'h00000200;
    expect_obs(3, mk(5'h00, 4'h0, 4'h0, 4'h0));
    ovtr_en <= 1'b1;
    expect_obs(3, mk(5'h04, 4'h0, 4'h0, 4'h0));
    meas.act_pos <= 32'h000001FF;
    meas.cmd_pos <= 32'h000001FF;
    pulse_clear();
    expect_obs(12, mk(5'h00, 4'h0, 4'h0, 4'h0));
    open_line <= 1'b1;
    trq <= 10'h0F9;
    expect_obs(12, mk(5'h00, 4'h0, 4'h0, 4'h0));
    trq <= 10'h0FA;
    expect_obs(3, mk(5'h10, 4'h0, 4'h0, 4'h0));
    open_line <= 1'b0;
    cyc(8);
    pulse_clear();
    expect_obs(12, mk(5'h00, 4'h0, 4'h0, 4'h0));
    meas.volt <= 16'($urandom_range(1, 65535));
    expect_obs(3, mk(5'h00, 4'h2, 4'h1, 4'h2));
    meas.load <= 16'($urandom_range(1, 65535));
    expect_obs(3, mk(5'h00, 4'h6, 4'h2, 4'h3));
    meas.volt <= 16'h0000;
    meas.load <= 16'h0000;
    expect_obs(3, mk(5'h00, 4'h0, 4'h2, 4'h3));
    meas.cmd_pos <= 32'h00000300;
    expect_obs(3, mk(5'h00, 4'h1, 4'h3, 4'h1));
    meas.cmd_pos <= 32'h000001FF;
    req[1:0] <= 2'h2;
    test_mode <= 1'b1;
    cyc(12);
    test_mode <= 1'b0;
    expect_obs(3, mk(5'h00, 4'h8, 4'h4, 4'h4));
    req[1:0] <= 2'h0;
    expect_obs(12, mk(5'h00, 4'h0, 4'h4, 4'h4));
    repeat (9) begin
      meas.load <= 16'h0001;
      cyc(2);
      meas.load <= 16'h0000;
      cyc(2);
    end
    meas.volt <= 16'h0001;
    expect_obs(3, mk(5'h00, 4'h2, 4'hA, 4'h2));
    meas.volt <= 16'h0000;
    idx <= 4'h9;
    expect_obs(3, mk(5'h00, 4'h0, 4'hA, 4'h3));
    clr_p <= 1'b1;
    idx <= 4'h0;
    cyc(1);
    clr_p <= 1'b0;
    expect_obs(2, mk(5'h00, 4'h0, 4'h0, 4'h0));
    meas.load <= 16'h0001;
    cyc(2);
    meas.load <= 16'h0000;
    clr_t <= 1'b1;
    cyc(1);
    clr_t <= 1'b0;
    expect_obs(2, mk(5'h00, 4'h0, 4'h0, 4'h0));
    therm <= 1'b1;
    expect_obs(12, mk(5'h02, 4'h0, 4'h0, 4'h0));
    therm <= 1'b0;
    cyc(4);
    // Deviation while not excited must not warn
    meas.cmd_pos <= 32'h00000300;
    pulse_clear();
    expect_obs(12, mk(5'h02, 4'h0, 4'h0, 4'h0));
    rst_in <= 1'b1;
    meas.cmd_pos <= 32'h000001FF;
    main_pwr <= 1'b0;
    sig_pwr <= 1'b0;
    cyc(5);
    rst_in <= 1'b0;
    expect_obs(2, mk(5'h00, 4'h0, 4'h0, 4'h0));
    main_pwr <= 1'b1;
    expect_obs(12, mk(5'h02, 4'h0, 4'h0, 4'h0));
    tally_and_finish();
  end
endmodule // tb
bind motor_fault_warning_manager fault_checks u_fault_checks (.mclk_in(mclk_in),
  .rst_in(rst_in), .torque_limit_pct_in(torque_limit_pct_in), .meas_in(meas_in),
  .op_in(op_in), .hist_clear_panel_in(hist_clear_panel_in),
  .hist_clear_tool_in(hist_clear_tool_in), .hist_count_out(hist_count_out),
  .alarm_out(alarm_out), .excite_out(excite_out), .brake_out(brake_out),
  .caution_output(caution_output), .warn_active_out(warn_active_out));
